// ### verilog/cache_defines.svh
`ifndef CACHE_DEFINES_SVH
`define CACHE_DEFINES_SVH
// ==========================================================
// Address fields (bit 0 is the least significant bit)
`define TAG_MSB 31
`define TAG_LSB 12
`define IDX_MSB 11
`define IDX_LSB 6
`define SEC_POS 5
`define BEAT_MSB 4
`define BEAT_LSB 3
`define WORD_POS 2
// ==========================================================
// Geometry and counts
`define NUM_WAYS 8
`define SET_SLOTS 512
`define SECT_SLOTS 1024
`define LAST_BEAT 2'h3
`define AGE_OLDEST 3'h7
`define BUF_FULL 3'h4
`define DARRAY_AW 12
`define DARRAY_DW 64
`endif

// ### verilog/cache_pkg.sv
package cache_pkg;
	// ==========================================================
	// Coherency state of one sector
	typedef enum logic [1:0] {
		MESI_I = 2'h0,
		MESI_S = 2'h1,
		MESI_E = 2'h2,
		MESI_M = 2'h3
	} mesi_type;

	// ==========================================================
	// System bus operations
	typedef enum logic [2:0] {
		OP_RD_SECT = 3'h0,
		OP_RD_EXCL = 3'h1,
		OP_WR_SECT = 3'h2,
		OP_RD_WORD = 3'h3,
		OP_WR_WORD = 3'h4,
		OP_CLAIM   = 3'h5
	} bus_op_type;

	// ==========================================================
	// Per-page or per-block access attributes
	typedef struct packed {
		logic wt;
		logic ci;
		logic coh;
	} page_attr_type;

	// ==========================================================
	// Controller states
	typedef enum logic [8:0] {
		ST_IDLE  = 9'h001,
		ST_LOOK  = 9'h002,
		ST_RDAT  = 9'h004,
		ST_EVICT = 9'h008,
		ST_WBUF  = 9'h010,
		ST_WBUS  = 9'h020,
		ST_FILL  = 9'h040,
		ST_FWR   = 9'h080,
		ST_SBUS  = 9'h100
	} fsm_type;
endpackage

// ### verilog/sector_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "cache_defines.svh"
module sector_ram #(
	parameter int AW = `DARRAY_AW,
	parameter int DW = `DARRAY_DW
) (
	input  wire logic            clk_i,
	input  wire logic [DW/8-1:0] we_i,
	input  wire logic [AW-1:0]   addr_i,
	input  wire logic [DW-1:0]   wdata_i,
	output logic      [DW-1:0]   rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Read returns the old word on a same-cycle write
	always_ff @(posedge clk_i) begin
		for (int b = 0; b < DW/8; b++) begin
			if (we_i[b]) begin
				mem[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
			end
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// ### verilog/unified_cache.sv
`timescale 1ns/1ps
`default_nettype none
`include "cache_defines.svh"
// Functional notes
// - One 32 KB eight-way unified cache
// - Physical tags; write-back and write-through supported
// - Update policy chosen per page or block
// - Policy, inhibit, coherency each per page
// - Eight ways of 64 lines each
// - Line: tag, two sectors, two state bits each
// - Sector: eight words; coherency unit
// - Line covers 16 aligned words within one page
// - Two bits encode M, E, S, I
// - M only copy; E sole; S shared; I empty
// - Fills, pushes and claims work on whole sectors
// - Optional low-priority fill of other sector
// - Least-recently-used line replaced on miss
// - Fill transfers missed double word first
// - Missed double word forwarded while written
// - Snoop port stalls core only on hit
// - Instruction block invalidate is a no-op
module unified_cache
	import cache_pkg::*;
(
	input  wire logic           CLK_I,
	input  wire logic           RST_I,
	input  wire logic           CORE_REQ_I,
	input  wire logic           CORE_ICBI_I,
	input  wire logic           CORE_WE_I,
	input  wire logic [3:0]     CORE_BE_I,
	input  wire logic [31:0]    CORE_ADDR_I,
	input  wire logic [31:0]    CORE_WDATA_I,
	input  wire page_attr_type  CORE_ATTR_I,
	input  wire logic           SEC_FILL_EN_I,
	output logic                CORE_ACK_O,
	output logic      [31:0]    CORE_RDATA_O,
	output logic                BUS_REQ_O,
	output bus_op_type          BUS_OP_O,
	output logic      [31:0]    BUS_ADDR_O,
	output logic      [7:0]     BUS_BE_O,
	output logic      [63:0]    BUS_WDATA_O,
	output logic                BUS_GBL_O,
	input  wire logic           BUS_ACK_I,
	input  wire logic [63:0]    BUS_RDATA_I,
	input  wire logic           BUS_SHR_I,
	input  wire logic           SNP_VALID_I,
	input  wire logic           SNP_KILL_I,
	input  wire logic [31:0]    SNP_ADDR_I,
	output logic                SNP_HIT_O,
	output logic                SNP_DIRTY_O
);
	// ==========================================================
	// Storage: tags, sector states, LRU ages
	logic [19:0]   tag [0:`SET_SLOTS-1];
	mesi_type      sst [0:`SECT_SLOTS-1];
	logic [2:0]    age [0:`SET_SLOTS-1];

	fsm_type       state;
	logic [31:0]   rq_addr;
	logic [31:0]   rq_wdata;
	logic [3:0]    rq_be;
	logic          rq_we;
	logic          rq_icbi;
	page_attr_type rq_attr;
	logic [2:0]    way;
	logic [1:0]    cnt;
	logic [1:0]    crit;
	logic [2:0]    ld;
	logic          sec;
	logic          alloc;
	logic          wb_snoop;
	mesi_type      wb_next;
	logic [31:0]   sa;
	logic [63:0]   sbuf [0:3];
	logic          sn_pend;
	logic          sn_kill;
	logic [2:0]    sn_way;
	logic [31:0]   sn_sa;

	logic [5:0]    idx;
	logic [5:0]    sidx;
	logic [5:0]    fidx;
	logic [7:0]    thit;
	logic [7:0]    shit;
	logic [7:0]    inv;
	logic [7:0]    sn_hitw;
	logic [2:0]    hway;
	logic [2:0]    sway;
	logic [2:0]    vway;
	logic          vfound;
	logic          vdirty;
	logic          snp_hit;
	mesi_type      hst;
	mesi_type      snp_st;
	logic [9:0]    rq_six;
	logic [9:0]    snp_six;
	logic [9:0]    fix;
	logic [9:0]    oix;
	logic [7:0]    be_mask;
	logic [31:0]   fill_word;
	logic          touch;
	logic [8:0]    touch_ix;
	logic [7:0]    m_we;
	logic [11:0]   m_addr;
	logic [63:0]   m_wdata;
	logic [63:0]   m_rdata;

	// ==========================================================
	// Lookup and snoop compare, one slice per way
	assign idx  = rq_addr[`IDX_MSB:`IDX_LSB];
	assign sidx = SNP_ADDR_I[`IDX_MSB:`IDX_LSB];
	assign fidx = sa[`IDX_MSB:`IDX_LSB];

	genvar gw;
	generate
		for (gw = 0; gw < `NUM_WAYS; gw++) begin : g_way
			logic teq;
			logic seq;
			assign teq = tag[{idx, 3'(gw)}] == rq_addr[`TAG_MSB:`TAG_LSB];
			assign inv[gw] = sst[{idx, 3'(gw), 1'b0}] == MESI_I &&
				sst[{idx, 3'(gw), 1'b1}] == MESI_I;
			assign thit[gw] = teq && !inv[gw];
			assign shit[gw] = teq &&
				sst[{idx, 3'(gw), rq_addr[`SEC_POS]}] != MESI_I;
			// Separate read port of the directory for snoops
			assign seq = tag[{sidx, 3'(gw)}] ==
				SNP_ADDR_I[`TAG_MSB:`TAG_LSB];
			assign sn_hitw[gw] = seq &&
				sst[{sidx, 3'(gw), SNP_ADDR_I[`SEC_POS]}] != MESI_I;
		end
	endgenerate

	always_comb begin
		hway   = 3'h0;
		sway   = 3'h0;
		vway   = 3'h0;
		vfound = 1'b0;
		for (int i = 0; i < `NUM_WAYS; i++) begin
			if (thit[i]) hway = 3'(i);
			if (sn_hitw[i]) sway = 3'(i);
			if (!vfound && inv[i]) begin
				vway   = 3'(i);
				vfound = 1'b1;
			end
		end
		// Empty ways are used before the oldest one
		if (!vfound) begin
			for (int i = 0; i < `NUM_WAYS; i++) begin
				if (age[{idx, 3'(i)}] == `AGE_OLDEST) vway = 3'(i);
			end
		end
	end

	assign snp_hit   = sn_hitw != 8'h00;
	assign snp_six   = {sidx, sway, SNP_ADDR_I[`SEC_POS]};
	assign snp_st    = sst[snp_six];
	assign rq_six    = {idx, way, rq_addr[`SEC_POS]};
	assign hst       = sst[{idx, hway, rq_addr[`SEC_POS]}];
	assign fix       = {fidx, way, sa[`SEC_POS]};
	assign oix       = {fidx, way, ~sa[`SEC_POS]};
	assign vdirty    = sst[{idx, way, 1'b0}] == MESI_M ||
		sst[{idx, way, 1'b1}] == MESI_M;
	assign be_mask   = rq_addr[`WORD_POS] ? {rq_be, 4'h0} : {4'h0, rq_be};
	assign fill_word = rq_addr[`WORD_POS] ? BUS_RDATA_I[63:32] :
		BUS_RDATA_I[31:0];
	assign touch = (state == ST_LOOK && !rq_icbi && !rq_attr.ci &&
		shit != 8'h00) || (state == ST_EVICT && alloc && !vdirty);
	assign touch_ix = {idx, (state == ST_LOOK) ? hway : way};

	// ==========================================================
	// Data array port steering
	always_comb begin
		m_we    = 8'h00;
		m_wdata = {2{rq_wdata}};
		m_addr  = {way, idx, rq_addr[`SEC_POS:`BEAT_LSB]};
		case (state)
			ST_LOOK: begin
				m_addr = {hway, idx, rq_addr[`SEC_POS:`BEAT_LSB]};
				if (shit != 8'h00 && rq_we && !rq_attr.ci && !rq_icbi &&
					(rq_attr.wt || hst != MESI_S)) m_we = be_mask;
			end
			ST_FWR: m_we = be_mask;
			ST_WBUF: m_addr = {way, fidx, sa[`SEC_POS], ld[1:0]};
			ST_FILL: begin
				m_addr  = {way, fidx, sa[`SEC_POS], 2'(crit + cnt)};
				m_wdata = BUS_RDATA_I;
				m_we    = BUS_ACK_I ? 8'hFF : 8'h00;
			end
			default: m_we = 8'h00;
		endcase
	end

	sector_ram u_data (
		.clk_i   (CLK_I),
		.we_i    (m_we),
		.addr_i  (m_addr),
		.wdata_i (m_wdata),
		.rdata_o (m_rdata)
	);

	// ==========================================================
	// Controller, directory and snoop state updates
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state <= ST_IDLE;
			CORE_ACK_O <= 1'b0;
			CORE_RDATA_O <= 32'h0000_0000;
			BUS_REQ_O <= 1'b0;
			BUS_OP_O <= OP_RD_SECT;
			BUS_ADDR_O <= 32'h0000_0000;
			BUS_BE_O <= 8'h00;
			BUS_WDATA_O <= 64'h0;
			BUS_GBL_O <= 1'b0;
			{rq_addr, rq_wdata, rq_be, rq_we, rq_icbi} <= '0;
			rq_attr <= '0;
			{way, cnt, crit, ld, sec, alloc, wb_snoop} <= '0;
			wb_next <= MESI_I;
			sa <= 32'h0000_0000;
			{sn_pend, sn_kill, sn_way, sn_sa} <= '0;
			for (int i = 0; i < `SECT_SLOTS; i++) begin
				sst[i] <= MESI_I;
			end
		end else begin
			CORE_ACK_O <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (sn_pend) begin
						// Push a snooped dirty sector before new core work
						way <= sn_way;
						sa <= {sn_sa[31:`SEC_POS], 5'h00};
						wb_next <= sn_kill ? MESI_I : MESI_S;
						wb_snoop <= 1'b1;
						BUS_GBL_O <= 1'b1;
						ld <= 3'h0;
						state <= ST_WBUF;
					end else if (CORE_REQ_I && !CORE_ACK_O &&
						!(SNP_VALID_I && snp_hit)) begin
						rq_addr <= CORE_ADDR_I;
						rq_wdata <= CORE_WDATA_I;
						rq_be <= CORE_BE_I;
						rq_we <= CORE_WE_I;
						rq_icbi <= CORE_ICBI_I;
						rq_attr <= CORE_ATTR_I;
						BUS_GBL_O <= CORE_ATTR_I.coh;
						state <= ST_LOOK;
					end
				end
				ST_LOOK: begin
					if (rq_icbi) begin
						CORE_ACK_O <= 1'b1;
						state <= ST_IDLE;
					end else if (rq_attr.ci || (rq_we && rq_attr.wt)) begin
						// Single word on the bus, no line allocated
						BUS_REQ_O <= 1'b1;
						BUS_OP_O <= rq_we ? OP_WR_WORD : OP_RD_WORD;
						BUS_ADDR_O <= rq_addr;
						BUS_BE_O <= be_mask;
						BUS_WDATA_O <= {2{rq_wdata}};
						state <= ST_SBUS;
					end else if (shit != 8'h00) begin
						way <= hway;
						if (!rq_we) begin
							state <= ST_RDAT;
						end else if (hst == MESI_S) begin
							// Other copies must go before the store
							BUS_REQ_O <= 1'b1;
							BUS_OP_O <= OP_CLAIM;
							BUS_ADDR_O <= {rq_addr[31:`SEC_POS], 5'h00};
							BUS_BE_O <= 8'h00;
							state <= ST_SBUS;
						end else begin
							sst[{idx, hway, rq_addr[`SEC_POS]}] <= MESI_M;
							CORE_ACK_O <= 1'b1;
							state <= ST_IDLE;
						end
					end else begin
						way <= (thit != 8'h00) ? hway : vway;
						alloc <= thit == 8'h00;
						state <= ST_EVICT;
					end
				end
				ST_RDAT: begin
					CORE_RDATA_O <= rq_addr[`WORD_POS] ? m_rdata[63:32] :
						m_rdata[31:0];
					CORE_ACK_O <= 1'b1;
					state <= ST_IDLE;
				end
				ST_EVICT: begin
					if (alloc && vdirty) begin
						sa <= {tag[{idx, way}], idx,
							sst[{idx, way, 1'b0}] != MESI_M, 5'h00};
						wb_next <= MESI_I;
						wb_snoop <= 1'b0;
						ld <= 3'h0;
						state <= ST_WBUF;
					end else begin
						if (alloc) begin
							tag[{idx, way}] <= rq_addr[`TAG_MSB:`TAG_LSB];
							sst[{idx, way, 1'b0}] <= MESI_I;
							sst[{idx, way, 1'b1}] <= MESI_I;
							alloc <= 1'b0;
						end
						sa <= rq_addr;
						crit <= rq_addr[`BEAT_MSB:`BEAT_LSB];
						cnt <= 2'h0;
						sec <= 1'b0;
						BUS_REQ_O <= 1'b1;
						BUS_OP_O <= rq_we ? OP_RD_EXCL : OP_RD_SECT;
						BUS_ADDR_O <= {rq_addr[31:`BEAT_LSB], 3'h0};
						BUS_BE_O <= 8'hFF;
						state <= ST_FILL;
					end
				end
				ST_WBUF: begin
					// Whole sector is staged so bus beats may come back to back
					ld <= ld + 3'h1;
					if (ld != 3'h0) sbuf[2'(ld - 3'h1)] <= m_rdata;
					if (ld == `BUF_FULL) begin
						BUS_REQ_O <= 1'b1;
						BUS_OP_O <= OP_WR_SECT;
						BUS_ADDR_O <= sa;
						BUS_BE_O <= 8'hFF;
						BUS_WDATA_O <= sbuf[0];
						cnt <= 2'h0;
						state <= ST_WBUS;
					end
				end
				ST_WBUS: begin
					if (BUS_ACK_I) begin
						cnt <= cnt + 2'h1;
						BUS_WDATA_O <= sbuf[2'(cnt + 2'h1)];
						if (cnt == `LAST_BEAT) begin
							BUS_REQ_O <= 1'b0;
							sst[fix] <= wb_next;
							if (wb_snoop) begin
								sn_pend <= 1'b0;
								state <= ST_IDLE;
							end else begin
								state <= ST_EVICT;
							end
						end
					end
				end
				ST_FILL: begin
					if (BUS_ACK_I) begin
						cnt <= cnt + 2'h1;
						if (cnt == 2'h0 && !sec && !rq_we) begin
							CORE_RDATA_O <= fill_word;
							CORE_ACK_O <= 1'b1;
						end
						if (cnt == `LAST_BEAT) begin
							BUS_REQ_O <= 1'b0;
							sst[fix] <= (BUS_SHR_I && (sec || !rq_we)) ?
								MESI_S : MESI_E;
							if (rq_we && !sec) begin
								state <= ST_FWR;
							end else if (!sec && SEC_FILL_EN_I &&
								sst[oix] == MESI_I && !CORE_REQ_I) begin
								// Yields to any waiting core request
								sec <= 1'b1;
								sa <= {rq_addr[31:`IDX_LSB], ~rq_addr[`SEC_POS],
									5'h00};
								crit <= 2'h0;
								BUS_REQ_O <= 1'b1;
								BUS_OP_O <= OP_RD_SECT;
								BUS_ADDR_O <= {rq_addr[31:`IDX_LSB],
									~rq_addr[`SEC_POS], 5'h00};
							end else begin
								state <= ST_IDLE;
							end
						end
					end
				end
				ST_FWR: begin
					sst[rq_six] <= MESI_M;
					CORE_ACK_O <= 1'b1;
					state <= ST_IDLE;
				end
				ST_SBUS: begin
					if (BUS_ACK_I) begin
						BUS_REQ_O <= 1'b0;
						if (BUS_OP_O == OP_CLAIM) begin
							state <= ST_FWR;
						end else begin
							if (!rq_we) CORE_RDATA_O <= fill_word;
							CORE_ACK_O <= 1'b1;
							state <= ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
			// Snoop updates come last so the external master wins
			if (SNP_VALID_I && snp_hit) begin
				if (snp_st == MESI_M) begin
					// A push ending now frees the slot, so a dirty hit in that cycle is kept
					if (!sn_pend || (wb_snoop && state == ST_WBUS &&
						BUS_ACK_I && cnt == `LAST_BEAT)) begin
						sn_pend <= 1'b1;
						sn_sa <= SNP_ADDR_I;
						sn_way <= sway;
						sn_kill <= SNP_KILL_I;
					end
				end else begin
					sst[snp_six] <= SNP_KILL_I ? MESI_I : MESI_S;
				end
			end
		end
	end

	// ==========================================================
	// LRU ages: touched way becomes youngest
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < `SET_SLOTS; i++) begin
				age[i] <= 3'(i);
			end
		end else if (touch) begin
			for (int w = 0; w < `NUM_WAYS; w++) begin
				if (age[{touch_ix[8:3], 3'(w)}] < age[touch_ix]) begin
					age[{touch_ix[8:3], 3'(w)}] <=
						age[{touch_ix[8:3], 3'(w)}] + 3'h1;
				end
			end
			age[touch_ix] <= 3'h0;
		end
	end

	// ==========================================================
	// Snoop answer
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			SNP_HIT_O <= 1'b0;
			SNP_DIRTY_O <= 1'b0;
		end else begin
			SNP_HIT_O <= SNP_VALID_I && snp_hit;
			SNP_DIRTY_O <= SNP_VALID_I && snp_hit && snp_st == MESI_M;
		end
	end

	// ==========================================================
	// Checks
	property p_icbi_noop;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_LOOK && rq_icbi) |=>
			CORE_ACK_O && !BUS_REQ_O && state == ST_IDLE;
	endproperty
	a_icbi_noop: assert property (p_icbi_noop)
		else $error("icbi not no-op");

	property p_ci_bypass;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_LOOK && rq_attr.ci && !rq_icbi) |=> state == ST_SBUS &&
			BUS_REQ_O && (BUS_OP_O == OP_RD_WORD || BUS_OP_O == OP_WR_WORD);
	endproperty
	a_ci_bypass: assert property (p_ci_bypass)
		else $error("ci allocated");

	property p_crit_first;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_FILL && BUS_REQ_O) |->
			BUS_ADDR_O[`BEAT_MSB:`BEAT_LSB] == crit && BUS_ADDR_O[2:0] == 3'h0;
	endproperty
	a_crit_first: assert property (p_crit_first)
		else $error("fill order");

	property p_forward;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_FILL && BUS_ACK_I && cnt == 2'h0 && !sec && !rq_we) |=>
			CORE_ACK_O && CORE_RDATA_O == $past(fill_word);
	endproperty
	a_forward: assert property (p_forward)
		else $error("no forward");

	property p_lru_touch;
		@(posedge CLK_I) disable iff (RST_I)
		touch |=> age[$past(touch_ix)] == 3'h0;
	endproperty
	a_lru_touch: assert property (p_lru_touch)
		else $error("lru stale");

	property p_wb_modify;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_FWR && !SNP_VALID_I) |=>
			sst[$past(rq_six)] == MESI_M && state == ST_IDLE && CORE_ACK_O;
	endproperty
	a_wb_modify: assert property (p_wb_modify)
		else $error("store not M");

	property p_wt_word;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_LOOK && rq_we && rq_attr.wt && !rq_icbi) |=>
			BUS_REQ_O && BUS_OP_O == OP_WR_WORD;
	endproperty
	a_wt_word: assert property (p_wt_word)
		else $error("wt write lost");

	property p_snoop_stall;
		@(posedge CLK_I) disable iff (RST_I)
		(state == ST_IDLE && CORE_REQ_I && !CORE_ACK_O && !sn_pend &&
			!(SNP_VALID_I && snp_hit)) |=> state == ST_LOOK;
	endproperty
	a_snoop_stall: assert property (p_snoop_stall)
		else $error("miss stall");

	property p_sec_fill;
		@(posedge CLK_I) disable iff (RST_I)
		$rose(sec) |-> $past(SEC_FILL_EN_I) && BUS_OP_O == OP_RD_SECT &&
			BUS_ADDR_O[4:0] == 5'h00;
	endproperty
	a_sec_fill: assert property (p_sec_fill)
		else $error("sector fill");
endmodule
`default_nettype wire

// ### testbench/sys_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module sys_bus_model
	import cache_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_i,
	input  wire bus_op_type  op_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  be_i,
	input  wire logic [63:0] wdata_i,
	input  wire logic [3:0]  lat_i,
	output logic             ack_o,
	output logic      [63:0] rdata_o
);
	// ==========================================================
	// Memory and request log
	logic [63:0] mem [logic [28:0]];
	bus_op_type  ops [$];
	logic [31:0] adrs [$];
	logic        act;
	logic        done;
	logic [1:0]  beat;
	logic [28:0] ba;
	logic [63:0] cur;
	int          left;
	int          waitc;

	initial begin
		ack_o = 1'b0;
		rdata_o = 64'h0;
		act = 1'b0;
		done = 1'b0;
	end

	// Acks and data launch on the falling edge so the cache samples them
	// cleanly; data lines toggle when no beat is carried
	always @(negedge clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		// A new address under a held request starts the next transfer
		if (!rst_i && req_i && done && addr_i != adrs[$]) begin
			act = 1'b0;
			done = 1'b0;
		end
		if (rst_i || !req_i) begin
			act = 1'b0;
			done = 1'b0;
		end else if (!done) begin
			if (!act) begin
				act = 1'b1;
				beat = (op_i == OP_WR_SECT) ? 2'h0 : addr_i[4:3];
				left = (op_i inside {OP_RD_SECT, OP_RD_EXCL, OP_WR_SECT}) ? 4 : 1;
				waitc = lat_i;
				ops.push_back(op_i);
				adrs.push_back(addr_i);
			end
			if (waitc > 0) begin
				waitc--;
			end else begin
				ba = (left == 1 && op_i inside {OP_RD_WORD, OP_WR_WORD, OP_CLAIM})
					? addr_i[31:3] : {addr_i[31:5], beat};
				cur = mem.exists(ba) ? mem[ba] : {~{ba, 3'h0}, {ba, 3'h0}};
				if (op_i inside {OP_WR_SECT, OP_WR_WORD}) begin
					for (int i = 0; i < 8; i++) begin
						if (be_i[i])
							cur[i*8 +: 8] = wdata_i[i*8 +: 8];
					end
					mem[ba] = cur;
				end
				rdata_o <= cur;
				ack_o <= 1'b1;
				beat = beat + 2'h1;
				left--;
				done = (left == 0);
				waitc = lat_i >> 1;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench/tb_unified_cache.sv
`timescale 1ns/1ps
`default_nettype none
module tb_unified_cache
	import cache_pkg::*;
;
	// ==========================================================
	// Signals and instances
	localparam page_attr_type WB = 3'h1;
	localparam page_attr_type WT = 3'h5;
	localparam page_attr_type CI = 3'h3;
	localparam logic [31:0]   A  = 32'h00012354;
	localparam logic [31:0]   B  = 32'h00045608;
	logic        clk, rst, req, icbi, we, sfill, shr, snv, snk;
	logic        ack, rq, gbl, bak, shit, sdrt;
	logic [3:0]  be, blat;
	logic [31:0] adr, wd, rdat, badr, sadr;
	logic [7:0]  bbe;
	logic [63:0] bwd, brd;
	page_attr_type at;
	bus_op_type  bop;
	int          n_errors = 0;
	int          checks = 0;

	always #12.5 clk = ~clk;

	unified_cache DUT (.CLK_I(clk), .RST_I(rst), .CORE_REQ_I(req),
		.CORE_ICBI_I(icbi), .CORE_WE_I(we), .CORE_BE_I(be), .CORE_ADDR_I(adr),
		.CORE_WDATA_I(wd), .CORE_ATTR_I(at), .SEC_FILL_EN_I(sfill),
		.CORE_ACK_O(ack), .CORE_RDATA_O(rdat), .BUS_REQ_O(rq), .BUS_OP_O(bop),
		.BUS_ADDR_O(badr), .BUS_BE_O(bbe), .BUS_WDATA_O(bwd), .BUS_GBL_O(gbl),
		.BUS_ACK_I(bak), .BUS_RDATA_I(brd), .BUS_SHR_I(shr),
		.SNP_VALID_I(snv), .SNP_KILL_I(snk), .SNP_ADDR_I(sadr),
		.SNP_HIT_O(shit), .SNP_DIRTY_O(sdrt));

	sys_bus_model PART (.clk_i(clk), .rst_i(rst), .req_i(rq), .op_i(bop),
		.addr_i(badr), .be_i(bbe), .wdata_i(bwd), .lat_i(blat),
		.ack_o(bak), .rdata_o(brd));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [63:0] e, g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] pat(input logic [31:0] a);
		return a[2] ? ~{a[31:3], 3'h0} : {a[31:3], 3'h0};
	endfunction

	function automatic int nreq();
		return PART.ops.size();
	endfunction

	task automatic acc(input logic w, ic, input page_attr_type pa,
		input logic [31:0] a, d, output logic [31:0] r, output int lat,
		output logic inb);
		@(negedge clk);
		req = 1'b1; we = w; icbi = ic; at = pa; adr = a; wd = d; lat = 0;
		while (ack !== 1'b1 && lat < 3000) begin
			@(negedge clk);
			lat++;
		end
		r = rdat;
		inb = rq;
		req = 1'b0;
	endtask

	task automatic rd(input logic [31:0] a);
		logic [31:0] r;
		int          l;
		logic        b;
		acc(1'b0, 1'b0, WB, a, 32'h0, r, l, b);
		chk("rdata", pat(a), r);
	endtask

	// Bus must stay quiet for a stretch before the next scenario looks
	task automatic idle();
		int c;
		c = 0;
		for (int i = 0; i < 500 && c < 12; i++) begin
			@(negedge clk);
			c = (rq === 1'b0) ? c + 1 : 0;
		end
	endtask

	task automatic snoop(input logic [31:0] a, output logic h, d);
		@(negedge clk);
		snv = 1'b1; sadr = a;
		@(negedge clk);
		snv = 1'b0; h = shit; d = sdrt;
		@(negedge clk);
		h = h | shit; d = d | sdrt;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_miss_hit();
		logic [31:0] r; int l; logic b; int n;
		n = nreq();
		acc(1'b0, 1'b0, WB, A, 32'h0, r, l, b);
		chk("miss data", pat(A), r);
		chk("fwd in fill", 1, b);
		chk("fill op", OP_RD_SECT, PART.ops[n]);
		chk("crit addr", {A[31:3], 3'h0}, PART.adrs[n]);
		idle();
		acc(1'b0, 1'b0, WB, A ^ 32'h8, 32'h0, r, l, b);
		chk("hit data", pat(A ^ 32'h8), r);
		chk("hit lat", 3, l);
		chk("nreq", n + 1, nreq());
	endtask

	task automatic t_icbi();
		logic [31:0] r; int l; logic b; int n;
		n = nreq();
		acc(1'b0, 1'b1, WB, 32'h00090000, 32'h0, r, l, b);
		chk("icbi lat", 2, l);
		idle();
		chk("icbi nreq", n, nreq());
	endtask

	task automatic t_inhib();
		logic [31:0] r; int l; logic b; int n;
		n = nreq();
		for (int i = 0; i < 2; i++) begin
			acc(1'b0, 1'b0, page_attr_type'(CI ^ 3'(i)), 32'h00077704,
				32'h0, r, l, b);
			chk("ci data", pat(32'h00077704), r);
			chk("ci gbl", i == 0, gbl);
		end
		idle();
		chk("ci nreq", n + 2, nreq());
		chk("ci op", OP_RD_WORD, PART.ops[n + 1]);
	endtask

	task automatic t_wthru();
		logic [31:0] r; int l; logic b; int n;
		n = nreq();
		acc(1'b1, 1'b0, WT, A, 32'hC0FFEE11, r, l, b);
		idle();
		chk("wt nreq", n + 1, nreq());
		chk("wt op", OP_WR_WORD, PART.ops[n]);
		chk("wt addr", A[31:2], PART.adrs[n][31:2]);
		acc(1'b0, 1'b0, WB, A, 32'h0, r, l, b);
		chk("wt read", 32'hC0FFEE11, r);
	endtask

	task automatic t_wback();
		logic [31:0] r; int l; logic b; int n; logic h, d;
		n = nreq();
		acc(1'b1, 1'b0, WB, A, 32'h5A5A1234, r, l, b);
		chk("wb lat", 2, l);
		chk("wb nreq", n, nreq());
		snoop(A, h, d);
		chk("snp hit", 1, h);
		chk("snp dirty", 1, d);
		idle();
		chk("push op", OP_WR_SECT, PART.ops[n]);
		chk("push addr", {A[31:5], 5'h0}, PART.adrs[n]);
		acc(1'b0, 1'b0, CI, A, 32'h0, r, l, b);
		chk("pushed data", 32'h5A5A1234, r);
		snoop(32'h00ABC000, h, d);
		chk("snp miss", 0, h);
	endtask

	task automatic t_sec();
		logic [31:0] r; int l; logic b; int n;
		sfill = 1'b1; blat = 4'h1;
		n = nreq();
		rd(B);
		idle();
		chk("sec nreq", n + 2, nreq());
		chk("sec op", OP_RD_SECT, PART.ops[n + 1]);
		chk("sec addr", {B[31:6], 1'b1}, PART.adrs[n + 1][31:5]);
		acc(1'b0, 1'b0, WB, B | 32'h20, 32'h0, r, l, b);
		chk("sec hit", 3, l);
		chk("sec nreq2", n + 2, nreq());
		sfill = 1'b0;
	endtask

	task automatic t_lru();
		int n;
		blat = 4'h3;
		n = nreq();
		for (int t = 1; t <= 8; t++)
			rd({t[19:0], 6'h2A, 6'h04});
		rd({20'h1, 6'h2A, 6'h04});
		chk("ways hit", n + 8, nreq());
		rd({20'h9, 6'h2A, 6'h04});
		rd({20'h1, 6'h2A, 6'h04});
		chk("lru keep", n + 9, nreq());
		rd({20'h2, 6'h2A, 6'h04});
		chk("lru evict", n + 10, nreq());
	endtask

	task automatic t_claim();
		logic [31:0] r; int l; logic b; int n; logic h, d;
		n = nreq();
		acc(1'b1, 1'b0, WB, A, 32'h0BADF00D, r, l, b);
		chk("claim op", OP_CLAIM, PART.ops[n]);
		acc(1'b0, 1'b0, WB, A, 32'h0, r, l, b);
		chk("claim data", 32'h0BADF00D, r);
		shr = 1'b1;
		rd(32'h00066604);
		idle();
		shr = 1'b0;
		acc(1'b1, 1'b0, WB, 32'h00066604, 32'h0, r, l, b);
		chk("shared claim", OP_CLAIM, PART.ops[n + 2]);
		acc(1'b1, 1'b0, WB, 32'h00099904, 32'h600DCAFE, r, l, b);
		chk("excl op", OP_RD_EXCL, PART.ops[n + 3]);
		snk = 1'b1;
		snoop(32'h00099904, h, d);
		snk = 1'b0;
		chk("kill dirty", 1, d);
		idle();
		chk("kill push", OP_WR_SECT, PART.ops[n + 4]);
		acc(1'b0, 1'b0, WB, 32'h00099904, 32'h0, r, l, b);
		chk("kill refill", 32'h600DCAFE, r);
		chk("kill nreq", n + 6, nreq());
	endtask

	// ==========================================================
	// Sequence and verdict
	task automatic finish_test();
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		clk = 1'b0; rst = 1'b1; req = 1'b0; icbi = 1'b0; we = 1'b0;
		sfill = 1'b0; shr = 1'b0; snv = 1'b0; snk = 1'b0; be = 4'hF;
		blat = 4'h0; adr = 32'h0; wd = 32'h0; sadr = 32'h0; at = WB;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		t_miss_hit();
		t_icbi();
		t_inhib();
		t_wthru();
		t_wback();
		t_sec();
		t_lru();
		t_claim();
		finish_test();
	end

	// Scenarios need well under a thousand cycles; this allows 60000, well over ten times
	initial begin
		#1500000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
